// ==== common/nd_cfg_pkg.sv ====
// Constants for the noise detector configuration bank.
// Assumes a 32-bit APB slave with one aligned word per register.
package nd_cfg_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_THRES_A = 8'h80;
  localparam logic [7:0] IDX_CFG_A   = 8'h81;
  localparam logic [7:0] IDX_THRES_B = 8'hA0;
  localparam logic [7:0] IDX_CFG_B   = 8'hA1;
  localparam logic [7:0] IDX_SET_SEL = 8'hC0;  // Active set select
  localparam logic [7:0] IDX_STATUS  = 8'hC1;  // Live status readback
  localparam int         ADDR_W      = 10;
  localparam int         IDX_LSB     = 2;
  // Configuration byte fields
  localparam int         SEL_MSB     = 5;
  localparam int         SEL_LSB     = 4;
  localparam int         LVL_MSB     = 3;
  localparam int         LVL_LSB     = 2;
  localparam int         SLEW_MSB    = 1;
  localparam int         SLEW_LSB    = 0;
  localparam int         CFG_W       = 6;      // Bits 7:6 are not kept
  // Status word fields
  localparam int         ST_SET      = 0;
  localparam int         ST_SEL_LSB  = 1;
  localparam int         ST_VALID    = 3;
  // Reset values
  localparam logic [7:0] THRES_RST   = 8'h00;
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  // Detection schemes
  typedef enum logic [1:0] {
    SCHEME_SQUELCH   = 2'h0,
    SCHEME_NOISE     = 2'h1,
    SCHEME_BOTH      = 2'h2,
    SCHEME_SQ_NOISLO = 2'h3
  } scheme_t;
endpackage

// ==== hw/fsk_noise_detector_config.sv ====
// APB register bank for the FSK noise detector, sets A and B.
// Assumes detector flags come from logic on pclk; no synchronisers.
//
// Functional notes
// - Two independent sets A/B, reset zero
// - Threshold is write-only full 8-bit byte
// - Bits 5:4 select the detection scheme
// - Scheme 3: noise path needs low threshold
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module fsk_noise_detector_config
  import nd_cfg_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sig_power_det,   // Squelch says signal
  input  wire logic              noise_quiet,     // Noise below threshold
  input  wire logic              low_signal_det,  // Low threshold exceeded
  output logic      [7:0]        noise_threshold_value,
  output scheme_t                detector_scheme_select,
  output logic      [1:0]        threshold_level_cfg,
  output logic      [1:0]        peak_slew_cfg,
  output logic                   signal_valid
);
  // Per-set storage
  logic [7:0]       thr_a;        // Set A threshold
  logic [7:0]       thr_b;        // Set B threshold
  logic [CFG_W-1:0] cfg_a;        // Set A config
  logic [CFG_W-1:0] cfg_b;        // Set B config
  logic             set_sel_reg;  // 0 picks A, 1 picks B
  logic             wr_en;        // Access phase write
  logic [CFG_W-1:0] cfg_act;      // Active config
  scheme_t          scheme;       // Active scheme
  logic             valid_next;   // Combined detector decision

  // Index decode, used for writes, reads and errors
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        i);
    hit = (a[ADDR_W-1:IDX_LSB] == i) && (a[IDX_LSB-1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, IDX_THRES_A) || hit(a, IDX_CFG_A) ||
             hit(a, IDX_THRES_B) || hit(a, IDX_CFG_B) ||
             hit(a, IDX_SET_SEL) || hit(a, IDX_STATUS);
  endfunction

  assign wr_en = psel && penable && pwrite && mapped(paddr);

  // Zero wait states; prdata is loaded during setup
  assign pready  = 1'b1;
  // Unmapped addresses flag an error in the access phase
  assign pslverr = psel && penable && !mapped(paddr);

  // Two independent copies, one per set
  noise_cfg_copy u_set_a (
    .pclk    (pclk),
    .presetn (presetn),
    .thr_we  (wr_en && hit(paddr, IDX_THRES_A)),
    .cfg_we  (wr_en && hit(paddr, IDX_CFG_A)),
    .wdata   (pwdata[7:0]),
    .thr     (thr_a),
    .cfg     (cfg_a)
  );

  noise_cfg_copy u_set_b (
    .pclk    (pclk),
    .presetn (presetn),
    .thr_we  (wr_en && hit(paddr, IDX_THRES_B)),
    .cfg_we  (wr_en && hit(paddr, IDX_CFG_B)),
    .wdata   (pwdata[7:0]),
    .thr     (thr_b),
    .cfg     (cfg_b)
  );

  // Active set select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_sel_reg <= 1'b0;
    end else if (wr_en && hit(paddr, IDX_SET_SEL)) begin
      set_sel_reg <= pwdata[0];
    end
  end

  // Read data; set registers are write-only and read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (hit(paddr, IDX_SET_SEL)) begin
        prdata[0] <= set_sel_reg;
      end else if (hit(paddr, IDX_STATUS)) begin
        prdata[ST_SET]               <= set_sel_reg;
        prdata[ST_SEL_LSB+1:ST_SEL_LSB] <= scheme;
        prdata[ST_VALID]             <= signal_valid;
      end
    end
  end

  // Active config follows the selected set
  assign cfg_act = set_sel_reg ? cfg_b : cfg_a;
  assign scheme  = scheme_t'(cfg_act[SEL_MSB:SEL_LSB]);

  // Scheme decision; noise path in scheme 3 needs low threshold
  always_comb begin
    case (scheme)
      SCHEME_SQUELCH:   valid_next = sig_power_det;
      SCHEME_NOISE:     valid_next = noise_quiet;
      SCHEME_BOTH:      valid_next = sig_power_det || noise_quiet;
      SCHEME_SQ_NOISLO: valid_next = sig_power_det ||
                                     (noise_quiet && low_signal_det);
      default:          valid_next = 1'b0;
    endcase
  end

  // Detector-facing outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_threshold_value  <= THRES_RST;
      detector_scheme_select <= SCHEME_SQUELCH;
      threshold_level_cfg    <= 2'h0;
      peak_slew_cfg          <= 2'h0;
      signal_valid           <= 1'b0;
    end else begin
      noise_threshold_value  <= set_sel_reg ? thr_b : thr_a;
      detector_scheme_select <= scheme;
      threshold_level_cfg    <= cfg_act[LVL_MSB:LVL_LSB];
      peak_slew_cfg          <= cfg_act[SLEW_MSB:SLEW_LSB];
      signal_valid           <= valid_next;
    end
  end

  // A write to set A leaves set B untouched
  sequence s_write_a;
    wr_en && (hit(paddr, IDX_THRES_A) || hit(paddr, IDX_CFG_A));
  endsequence

  a_set_b_independent: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_write_a |=> ($stable(thr_b) && $stable(cfg_b)))
    else $error("set B changed on a set A write");

  a_thres_full_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, IDX_THRES_A) && !set_sel_reg)
      |=> ##1 (noise_threshold_value == $past(pwdata[7:0], 2)))
    else $error("threshold output does not match written byte");

  a_thres_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && hit(paddr, IDX_THRES_B)) |=> (prdata == 32'h0))
    else $error("write-only threshold read nonzero");

  a_squelch_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scheme == SCHEME_SQUELCH) |=> (signal_valid == $past(sig_power_det)))
    else $error("squelch scheme does not follow signal power");

  a_noise_needs_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scheme == SCHEME_SQ_NOISLO && !sig_power_det && !low_signal_det)
      |=> !signal_valid)
    else $error("noise path valid without low threshold");

  a_cfg_top_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, IDX_CFG_A)) |=> (cfg_a == $past(pwdata[5:0])))
    else $error("config write stored wrong bits");

  // Same bit drop on set B, so both copies behave alike
  a_cfg_b_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, IDX_CFG_B)) |=> (cfg_b == $past(pwdata[5:0])))
    else $error("set B config write stored wrong bits");

  // A write to set B leaves set A untouched
  sequence s_write_b;
    wr_en && (hit(paddr, IDX_THRES_B) || hit(paddr, IDX_CFG_B));
  endsequence

  a_set_a_independent: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_write_b |=> ($stable(thr_a) && $stable(cfg_a)))
    else $error("set A changed on a set B write");

  // Set B threshold keeps all eight bits
  a_thres_b_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, IDX_THRES_B)) |=> (thr_b == $past(pwdata[7:0])))
    else $error("set B threshold does not match written byte");

  // Noise-only scheme ignores the squelch input
  a_noise_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scheme == SCHEME_NOISE) |=> (signal_valid == $past(noise_quiet)))
    else $error("noise scheme does not follow noise detector");

  // Either detector may report a signal in scheme 2
  a_both_detect: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scheme == SCHEME_BOTH)
      |=> (signal_valid == ($past(sig_power_det) || $past(noise_quiet))))
    else $error("combined scheme does not follow either detector");

  // Quiet noise plus low threshold is enough in scheme 3
  a_noise_low_pass: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scheme == SCHEME_SQ_NOISLO && noise_quiet && low_signal_det)
      |=> signal_valid)
    else $error("noise path not valid with low threshold exceeded");
endmodule

// ==== hw/noise_cfg_copy.sv ====
// One configuration set: noise threshold and detector configuration.
// Assumes write strobes are single-cycle and already decoded.
`timescale 1ns/1ps
module noise_cfg_copy
  import nd_cfg_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             thr_we,   // Threshold write strobe
  input  wire logic             cfg_we,   // Config write strobe
  input  wire logic [7:0]       wdata,    // Write byte
  output logic      [7:0]       thr,      // Stored threshold
  output logic      [CFG_W-1:0] cfg       // Stored config bits 5:0
);
  // Threshold keeps the whole byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr <= THRES_RST;
    end else if (thr_we) begin
      thr <= wdata;
    end
  end

  // Upper two bits dropped, so writes there have no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RST;
    end else if (cfg_we) begin
      cfg <= wdata[CFG_W-1:0];
    end
  end
endmodule

// ==== tb/tb_fsk_noise_detector_config.sv ====
// Bench for the noise detector register bank: APB tasks and checks.
// Assumes the package is compiled first; one clock, no partner model.
`timescale 1ns/1ps
module tb_fsk_noise_detector_config
  import nd_cfg_pkg::*;
;
  // Compare, count and report at once
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
  logic              pclk = 1'b0;     // Bus clock
  logic              presetn = 1'b0;  // Held low at start
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [31:0]       rd;              // Last read word
  logic              err;             // Last error flag
  logic              sig_power_det = 1'b0;
  logic              noise_quiet = 1'b0;
  logic              low_signal_det = 1'b0;
  logic [7:0]        noise_threshold_value;
  scheme_t           detector_scheme_select;
  logic [1:0]        threshold_level_cfg;
  logic [1:0]        peak_slew_cfg;
  logic              signal_valid;
  int                n_fail = 0;
  int                total_checks = 0;

  fsk_noise_detector_config i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sig_power_det,
    .noise_quiet, .low_signal_det, .noise_threshold_value,
    .detector_scheme_select, .threshold_level_cfg, .peak_slew_cfg,
    .signal_valid);

  // 100 ns period
  always #50 pclk = ~pclk;

  // Verdict in one place
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One APB transfer; an idle edge first so strobes never rise twice
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Active outputs as one 6-bit word: scheme, level, slew
  function automatic logic [5:0] cfg_now();
    return {detector_scheme_select, threshold_level_cfg, peak_slew_cfg};
  endfunction

  // Sweep all detector input combinations under one scheme of set B
  task automatic scheme_run(input logic [1:0] s);
    logic [2:0] v;
    logic       e;
    apb(1'b1, 10'h284, {26'h0, s, 4'h7});
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      @(posedge pclk);
      sig_power_det <= v[2];
      noise_quiet <= v[1];
      low_signal_det <= v[0];
      case (s)
        2'h0: e = v[2];
        2'h1: e = v[1];
        2'h2: e = v[2] | v[1];
        default: e = v[2] | (v[1] & v[0]);
      endcase
      repeat (2) @(posedge pclk);
      #1;
      `CHK(signal_valid, e)
    end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK(noise_threshold_value, 8'h00)
    `CHK(cfg_now(), 6'h00)
    apb(1'b0, 10'h200, 32'h0);
    `CHK(rd, 32'h0)
    // Thresholds stand in for values taken from noise power readings
    // Upper bits set on purpose: only bits 5:0 of config may stick
    apb(1'b1, 10'h200, 32'hFFFF_FF5A);
    apb(1'b1, 10'h204, 32'hFFFF_FFF7);
    apb(1'b1, 10'h280, 32'h0000_00A5);
    apb(1'b1, 10'h284, 32'h0000_0027);
    repeat (3) @(posedge pclk);
    #1;
    `CHK(noise_threshold_value, 8'h5A)
    `CHK(cfg_now(), 6'h37)
    apb(1'b0, 10'h204, 32'h0);
    `CHK(rd, 32'h0)
    // Switch to set B; A must not have leaked into it
    apb(1'b1, 10'h300, 32'h1);
    repeat (3) @(posedge pclk);
    #1;
    `CHK(noise_threshold_value, 8'hA5)
    `CHK(cfg_now(), 6'h27)
    apb(1'b0, 10'h304, 32'h0);
    `CHK(rd[2:0], 3'h5)
    // Unmapped place is refused
    apb(1'b1, 10'h3FC, 32'h55);
    `CHK(err, 1'b1)
    apb(1'b0, 10'h3FC, 32'h0);
    `CHK(rd, 32'h0)
    for (int s = 0; s < 4; s++) begin
      scheme_run(s[1:0]);
    end
    tally_and_finish();
  end

  // Watchdog well beyond the roughly 150 cycles needed
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule
